/* File: core/urxsf_pkg.sv */
// Constants for the receiver status flag block.
// Assumes a single bus clock and a plain register port.
package urxsf_pkg;
  localparam logic [1:0] ADDR_STATUS    = 2'h0;
  localparam logic [1:0] ADDR_EXTRA     = 2'h1;
  localparam logic [1:0] ADDR_DATA      = 2'h2;
  localparam logic [1:0] ADDR_CTRL      = 2'h3;
  localparam int         BIT_RX_FULL    = 5;
  localparam int         BIT_IDLE       = 4;
  localparam int         BIT_OVERRUN    = 3;
  localparam int         BIT_NOISE      = 2;
  localparam int         BIT_FRAMING    = 1;
  localparam int         BIT_PARITY     = 0;
  localparam int         BIT_LONG_BRK   = 2;
  localparam int         BIT_ACTIVE     = 0;
  localparam int         CTRL_NINTH     = 0;
  localparam int         CTRL_PAR_EN    = 1;
  localparam int         CTRL_PAR_ODD   = 2;
  localparam int         CTRL_IDLE_STOP = 3;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam int         SAMPLES_BIT    = 16;
  localparam int         CHAR_BITS      = 10;
  localparam int         CHAR_BITS_9    = 11;
  localparam int         BRK_BITS       = 10;
  localparam int         BRK_BITS_9     = 11;
  localparam int         BRK_BITS_L     = 13;
  localparam int         BRK_BITS_L9    = 14;
  localparam int         BAUD_DIV_RESET = 13;
  typedef enum logic [1:0] {URXSF_IDLE, URXSF_START, URXSF_DATA, URXSF_STOP} urxsf_state_t;
endpackage : urxsf_pkg

/* File: core/urxsf_top.sv */
// Receiver with status flags, clear sequence, idle detection and break length select.
// Assumes rx pin is asynchronous; sample tick is bus clock divided by a divider input.
// Behaviour
// [R1] Idle flag sets after high line for 10 bit times, 11 in nine-bit mode.
// [R2] Idle-after-stop 0: idle counting starts right after the start bit.
// [R3] Idle-after-stop 1: idle counting starts only after the stop bit.
// [R4] Idle flag clears on status read with flag set, then data read.
// [R5] Once cleared, idle flag waits for a new character with full flag set.
// [R6] Idle flag raises only once per idle period.
// [R7] Overrun sets when new character finds buffer full; new character discarded.
// [R8] Overrun clears on status read with flag set, then data read.
// [R9] Seven samples in start bit, three in each data and stop bit.
// [R10] Any disagreeing sample sets noise flag with the full flag.
// [R11] Noise flag clears on status read then data read.
// [R12] Framing error sets with full flag when stop bit samples as 0.
// [R13] Framing flag clears on status read with flag set, then data read.
// [R14] With parity enabled, parity mismatch sets parity flag with full flag.
// [R15] Parity flag clears on status read then data read.
// [R16] Long break select picks 10/11 or 13/14 bit break length.
// [R17] Framing detection does not depend on long break select.
// [R18] Active flag sets on valid start bit, clears on idle detection.
// [R19] Full flag and error flags update when character moves to buffer.
// [R20] All flags are zero after reset.
`timescale 1ns/1ps
`default_nettype none
module urxsf_top #(
  parameter int DIV_W = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_rx,
  input  wire logic [DIV_W-1:0] i_baud_div,
  input  wire logic [1:0]       i_addr,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [7:0]       o_rdata,
  output logic                  o_break_det
);
  logic                    rx_meta_q;
  logic                    rx_sync_q;
  logic [DIV_W-1:0]        div_q;
  logic                    tick;
  logic [3:0]              ph_q;
  logic [3:0]              bit_q;
  logic [2:0]              vote_q;
  logic [2:0]              cnt_q;
  logic                    noisy_q;
  logic                    par_q;
  logic [8:0]              shift_q;
  urxsf_pkg::urxsf_state_t st_q;
  logic [7:0]              data_q;
  logic                    ninth_q;
  logic [3:0]              ctrl_q;
  logic                    long_brk_q;
  logic                    full_q;
  logic                    idle_q;
  logic                    ovr_q;
  logic                    noise_q;
  logic                    fe_q;
  logic                    pf_q;
  logic                    act_q;
  logic                    armed_q;
  logic                    idle_run_q;
  logic [3:0]              idle_cnt_q;
  logic [3:0]              brk_cnt_q;
  logic                    stat_seen_q;
  logic                    done;
  logic                    load;
  logic                    idle_hit;
  logic                    samp;
  logic                    maj;
  logic                    bit_end;
  logic [3:0]              nbits;
  logic [3:0]              char_len;
  logic [3:0]              brk_len;
  logic                    clr_seq;
  logic                    stop_ok;
  logic                    par_bad;
  logic                    cur_noise;
  logic [7:0]              status_byte;

  // Synchroniser for the receive pin
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= i_rx;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Sample tick at sixteen per bit
  assign tick = (div_q == '0);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_q <= DIV_W'(urxsf_pkg::BAUD_DIV_RESET);
    end else if (tick) begin
      div_q <= i_baud_div;
    end else begin
      div_q <= div_q - 1'b1;
    end
  end

  assign nbits    = ctrl_q[urxsf_pkg::CTRL_NINTH] ? 4'h9 : 4'h8;
  assign char_len = ctrl_q[urxsf_pkg::CTRL_NINTH] ? 4'(urxsf_pkg::CHAR_BITS_9) : 4'(urxsf_pkg::CHAR_BITS); // [R1]
  assign brk_len  = long_brk_q ? (ctrl_q[urxsf_pkg::CTRL_NINTH] ? 4'(urxsf_pkg::BRK_BITS_L9) : 4'(urxsf_pkg::BRK_BITS_L))
                               : (ctrl_q[urxsf_pkg::CTRL_NINTH] ? 4'(urxsf_pkg::BRK_BITS_9) : 4'(urxsf_pkg::BRK_BITS)); // [R16]
  assign bit_end  = tick && (ph_q == 4'hF);
  // Samples at phases 7, 8, 9 of each bit; start bit also at 3, 5, 10, 11
  assign samp = tick && ((ph_q == 4'h7) || (ph_q == 4'h8) || (ph_q == 4'h9) ||
                ((st_q == urxsf_pkg::URXSF_START) && ((ph_q == 4'h3) || (ph_q == 4'h5) ||
                (ph_q == 4'hA) || (ph_q == 4'hB)))); // [R9]
  assign maj = (st_q == urxsf_pkg::URXSF_START) ? (cnt_q >= 3'h4) : (cnt_q >= 3'h2);
  // Noise if the bit's samples are not unanimous
  assign cur_noise = (st_q == urxsf_pkg::URXSF_START) ? ((cnt_q != 3'h0) && (cnt_q != 3'h7))
                                           : ((cnt_q != 3'h0) && (cnt_q != 3'h3)); // [R10]
  assign stop_ok = maj; // [R12] [R17]
  assign par_bad = ctrl_q[urxsf_pkg::CTRL_PAR_EN] &&
                   (((ctrl_q[urxsf_pkg::CTRL_NINTH] ? ^shift_q[7:0] : ^shift_q[7:1]) ^ par_q)
                    != ctrl_q[urxsf_pkg::CTRL_PAR_ODD]); // [R14]
  assign done = (st_q == urxsf_pkg::URXSF_STOP) && bit_end;
  // Character moves to the buffer unless the buffer is still unread
  assign load     = done && !(full_q && !clr_seq);
  assign idle_hit = (idle_cnt_q == char_len) && !idle_run_q;

  // Receive state machine
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q    <= urxsf_pkg::URXSF_IDLE;
      ph_q    <= 4'h0;
      bit_q   <= 4'h0;
      cnt_q   <= 3'h0;
      noisy_q <= 1'b0;
      par_q   <= 1'b0;
      shift_q <= 9'h000;
      vote_q  <= 3'h0;
    end else begin
      if (tick) begin
        ph_q <= ph_q + 4'h1;
      end
      if (samp) begin
        cnt_q <= cnt_q + {2'b00, rx_sync_q};
      end
      case (st_q)
        urxsf_pkg::URXSF_IDLE: begin
          if (!rx_sync_q) begin
            st_q    <= urxsf_pkg::URXSF_START;
            ph_q    <= 4'h0;
            cnt_q   <= 3'h0;
            noisy_q <= 1'b0;
            par_q   <= 1'b0;
          end
        end
        urxsf_pkg::URXSF_START: begin
          if (tick && ph_q == 4'hB && (cnt_q + {2'b00, rx_sync_q}) >= 3'h4) begin
            st_q <= urxsf_pkg::URXSF_IDLE;
          end else if (bit_end) begin
            noisy_q <= cur_noise;
            cnt_q   <= 3'h0;
            bit_q   <= 4'h0;
            st_q    <= urxsf_pkg::URXSF_DATA;
          end
        end
        urxsf_pkg::URXSF_DATA: begin
          if (bit_end) begin
            noisy_q <= noisy_q | cur_noise;
            cnt_q   <= 3'h0;
            shift_q <= {maj, shift_q[8:1]};
            if (ctrl_q[urxsf_pkg::CTRL_PAR_EN] && bit_q == nbits - 4'h1) begin
              par_q <= maj;
            end
            bit_q <= bit_q + 4'h1;
            if (bit_q == nbits - 4'h1) begin
              st_q <= urxsf_pkg::URXSF_STOP;
            end
          end
        end
        urxsf_pkg::URXSF_STOP: begin
          if (bit_end) begin
            vote_q <= {stop_ok, cur_noise, par_bad};
            st_q   <= urxsf_pkg::URXSF_IDLE;
          end
        end
        default: st_q <= urxsf_pkg::URXSF_IDLE;
      endcase
    end
  end

  // Clear sequence: status read arms, data read clears
  assign clr_seq = i_rd && (i_addr == urxsf_pkg::ADDR_DATA) && stat_seen_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_seen_q <= 1'b0;
    end else if (i_rd && i_addr == urxsf_pkg::ADDR_STATUS) begin
      stat_seen_q <= full_q | idle_q | ovr_q | noise_q | fe_q | pf_q; // [R4] [R8] [R13]
    end else if (clr_seq) begin
      stat_seen_q <= 1'b0;
    end
  end

  // Overrun flag; a clearing data read in the same cycle wins, so no overrun sets and the character loads
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ovr_q <= 1'b0; // [R20]
    end else if (done && full_q && !clr_seq) begin
      ovr_q <= 1'b1; // [R7]
    end else if (clr_seq) begin
      ovr_q <= 1'b0; // [R8]
    end
  end

  // Receive-full flag
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      full_q <= 1'b0; // [R20]
    end else if (load) begin
      full_q <= 1'b1; // [R19]
    end else if (clr_seq) begin
      full_q <= 1'b0;
    end
  end

  // Receive data buffer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      data_q  <= urxsf_pkg::RESET_BYTE;
      ninth_q <= 1'b0;
    end else if (load) begin
      data_q  <= ctrl_q[urxsf_pkg::CTRL_NINTH] ? shift_q[7:0] : shift_q[8:1]; // [R19]
      ninth_q <= shift_q[8];
    end
  end

  // Error flags, updated with the buffer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      noise_q <= 1'b0; // [R20]
      fe_q    <= 1'b0;
      pf_q    <= 1'b0;
    end else if (load) begin
      noise_q <= noisy_q | cur_noise; // [R10]
      fe_q    <= !stop_ok; // [R12]
      pf_q    <= par_bad; // [R14]
    end else if (clr_seq) begin
      noise_q <= 1'b0; // [R11]
      fe_q    <= 1'b0; // [R13]
      pf_q    <= 1'b0; // [R15]
    end
  end

  // Receiver active flag
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      act_q <= 1'b0; // [R20]
    end else if (idle_hit) begin
      act_q <= 1'b0; // [R18]
    end else if (st_q == urxsf_pkg::URXSF_START && bit_end) begin
      act_q <= 1'b1; // [R18]
    end
  end

  // Idle detection armed by a received character
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      armed_q <= 1'b0;
    end else if (idle_hit && armed_q) begin
      armed_q <= 1'b0;
    end else if (load) begin
      armed_q <= 1'b1; // [R5]
    end
  end

  // One idle event per idle period
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idle_run_q <= 1'b0;
    end else if (idle_hit) begin
      idle_run_q <= 1'b1; // [R6]
    end else if (!rx_sync_q || (st_q == urxsf_pkg::URXSF_START)) begin
      idle_run_q <= 1'b0;
    end
  end

  // Idle bit time counter
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idle_cnt_q <= 4'h0;
    end else if (!rx_sync_q || (st_q == urxsf_pkg::URXSF_START)) begin
      idle_cnt_q <= 4'h0;
    end else if (ctrl_q[urxsf_pkg::CTRL_IDLE_STOP] && st_q != urxsf_pkg::URXSF_IDLE) begin
      idle_cnt_q <= 4'h0; // [R3]
    end else if (bit_end && idle_cnt_q != char_len) begin
      idle_cnt_q <= idle_cnt_q + 4'h1; // [R2]
    end
  end

  // Idle line flag
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idle_q <= 1'b0; // [R20]
    end else if (idle_hit && armed_q) begin
      idle_q <= 1'b1; // [R1]
    end else if (clr_seq) begin
      idle_q <= 1'b0; // [R4]
    end
  end

  // Break length counter
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      brk_cnt_q <= 4'h0;
    end else if (rx_sync_q) begin
      brk_cnt_q <= 4'h0;
    end else if (bit_end && brk_cnt_q != brk_len) begin
      brk_cnt_q <= brk_cnt_q + 4'h1;
    end
  end

  // Break detect: low for the selected break length
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_break_det <= 1'b0;
    end else if (rx_sync_q) begin
      o_break_det <= 1'b0;
    end else if (brk_cnt_q == brk_len) begin
      o_break_det <= 1'b1; // [R16]
    end
  end

  // Control registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q     <= 4'h0;
      long_brk_q <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == urxsf_pkg::ADDR_CTRL) begin
        ctrl_q <= i_wdata[3:0];
      end
      if (i_addr == urxsf_pkg::ADDR_EXTRA) begin
        long_brk_q <= i_wdata[urxsf_pkg::BIT_LONG_BRK];
      end
    end
  end

  assign status_byte = {2'b00, full_q, idle_q, ovr_q, noise_q, fe_q, pf_q};

  // Read data, one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        urxsf_pkg::ADDR_STATUS: begin
          o_rdata <= status_byte;
        end
        urxsf_pkg::ADDR_EXTRA: begin
          o_rdata <= {5'h00, long_brk_q, 1'b0, act_q};
        end
        urxsf_pkg::ADDR_DATA: begin
          o_rdata <= data_q;
        end
        urxsf_pkg::ADDR_CTRL: begin
          o_rdata <= {3'h0, ninth_q, ctrl_q};
        end
        default: begin
          o_rdata <= 8'h00;
        end
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule : urxsf_top
`default_nettype wire

/* File: test/urxsf_assertions.sv */
// Checker on the receiver status block ports.
// Assumes it is bound into urxsf_top; status flags are seen through register reads, break detect at its port.
`timescale 1ns/1ps
`default_nettype none
module urxsf_assertions #(
  parameter int DIV_W = 8
) (
  input wire logic             i_clk,
  input wire logic             i_arst_n,
  input wire logic             i_rx,
  input wire logic [DIV_W-1:0] i_baud_div,
  input wire logic [1:0]       i_addr,
  input wire logic [7:0]       i_wdata,
  input wire logic             i_wr,
  input wire logic             i_rd,
  input wire logic [7:0]       o_rdata,
  input wire logic             o_break_det
);
  logic [19:0] low_q;
  logic        par_q, ninth_q, long_q, fell_q, rdp_q, st_q, ex_q;
  int          bitc, brk;
  assign bitc = urxsf_pkg::SAMPLES_BIT * (int'(i_baud_div) + 1);
  assign brk  = long_q ? (ninth_q ? 14 : 13) : (ninth_q ? 11 : 10);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_q <= 20'h0;
      {par_q, ninth_q, long_q, fell_q, rdp_q, st_q, ex_q} <= 7'h0;
    end else begin
      low_q  <= i_rx ? 20'h0 : low_q + 20'h1;
      fell_q <= fell_q | ~i_rx;
      rdp_q  <= i_rd;
      st_q   <= i_rd && i_addr == urxsf_pkg::ADDR_STATUS;
      ex_q   <= i_rd && i_addr == urxsf_pkg::ADDR_EXTRA;
      if (i_wr && i_addr == urxsf_pkg::ADDR_CTRL) {par_q, ninth_q} <= i_wdata[1:0];
      if (i_wr && i_addr == urxsf_pkg::ADDR_EXTRA) long_q <= i_wdata[2];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  AST_RDATA_ZERO: assert property (!rdp_q |-> o_rdata == 8'h00)
    else $error("read data outside read cycle");
  AST_STATUS_HI: assert property (st_q |-> o_rdata[7:6] == 2'h0)
    else $error("status upper bits set");
  AST_EXTRA_B1: assert property (ex_q |-> !o_rdata[1])
    else $error("extra bit1 set");
  AST_EXTRA_LONG: assert property (ex_q |-> o_rdata[2] == $past(long_q))
    else $error("long break readback wrong");
  AST_PAR_OFF: assert property (st_q && !$past(par_q, 2) |-> !o_rdata[0])
    else $error("parity flag with parity off");
  AST_QUIET: assert property (rdp_q && !$past(fell_q) |-> o_rdata == 8'h00)
    else $error("flag set without line activity");
  AST_BRK_MIN: assert property ($rose(o_break_det) |-> low_q >= 20'((brk - 1) * bitc))
    else $error("break flagged too early");
  AST_BRK_MAX: assert property (low_q == 20'((brk + 1) * bitc) |-> o_break_det)
    else $error("break flagged too late");
  COV_BRK: cover property ($rose(o_break_det));
  COV_OVR: cover property (st_q && o_rdata[urxsf_pkg::BIT_OVERRUN]);
  COV_NZ: cover property (st_q && o_rdata[urxsf_pkg::BIT_NOISE]);
endmodule : urxsf_assertions
bind urxsf_top urxsf_assertions #(.DIV_W(DIV_W)) urxsf_assertions_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_rx(i_rx), .i_baud_div(i_baud_div), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_break_det(o_break_det));
`default_nettype wire

/* File: test/urxsf_tx_model.sv */
// Remote serial transmitter model on the receive line.
// Assumes the bench calls its tasks; the line idles high between frames.
`timescale 1ns/1ps
`default_nettype none
module urxsf_tx_model #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic i_clk,
  output var logic  o_rx
);
  initial o_rx = 1'b1;
  // Frame is sent LSB first; glitch flips one sample of data bit 0
  task automatic send(input logic [9:0] frame, input logic glitch);
    for (int b = 0; b < 10; b++) begin
      for (int c = 0; c < BIT_CLKS; c++) begin
        @(posedge i_clk);
        o_rx <= frame[b] ^ (glitch && b == 1 && c >= 18 && c < 20);
      end
    end
    @(posedge i_clk);
    o_rx <= 1'b1;
  endtask : send
  task automatic hold_low(input int nbits);
    @(posedge i_clk);
    o_rx <= 1'b0;
    repeat (nbits * BIT_CLKS) @(posedge i_clk);
    o_rx <= 1'b1;
  endtask : hold_low
endmodule : urxsf_tx_model
`default_nettype wire

/* File: test/urxsf_top_tb.sv */
// Bench for the receiver status block: register tasks and one task per scenario.
// Assumes the transmitter model drives the receive line; bit time is 32 clocks.
`timescale 1ns/1ps
`default_nettype none
module urxsf_top_tb;
  localparam int         BC = 32;
  localparam logic [1:0] AS = urxsf_pkg::ADDR_STATUS, AE = urxsf_pkg::ADDR_EXTRA;
  localparam logic [1:0] AD = urxsf_pkg::ADDR_DATA, AC = urxsf_pkg::ADDR_CTRL;
  localparam logic [7:0] FULL = 8'h01 << urxsf_pkg::BIT_RX_FULL, IDL = 8'h01 << urxsf_pkg::BIT_IDLE;
  localparam logic [7:0] OVR = 8'h01 << urxsf_pkg::BIT_OVERRUN, NZ = 8'h01 << urxsf_pkg::BIT_NOISE;
  localparam logic [7:0] FRM = 8'h01 << urxsf_pkg::BIT_FRAMING, PAR = 8'h01 << urxsf_pkg::BIT_PARITY;
  localparam logic [7:0] ACT = 8'h01 << urxsf_pkg::BIT_ACTIVE;
  logic       clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, rx, brk;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, bdiv = 8'h01, rdata, d;
  int         err_count = 0, checks_done = 0;
  always #20 clk = ~clk;
  urxsf_top #(.DIV_W(8)) urxsf_top_inst (.i_clk(clk), .i_arst_n(arst_n), .i_rx(rx), .i_baud_div(bdiv),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_break_det(brk));
  urxsf_tx_model #(.BIT_CLKS(BC)) urxsf_tx_model_inst (.i_clk(clk), .o_rx(rx));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic bits(input int n);
    repeat (n * BC) @(posedge clk);
    #1;
  endtask : bits
  task automatic st_dat(input logic [7:0] s, input logic [7:0] dv);
    rd_reg(AS, d);
    chk(d, s);
    rd_reg(AD, d);
    chk(d, dv);
  endtask : st_dat
  task automatic t_reset();
    wr_reg(AS, 8'hFF);
    rd_reg(AS, d);
    chk(d, 8'h00);
    rd_reg(AE, d);
    chk(d, 8'h00);
  endtask : t_reset
  task automatic t_clean();
    fork
      urxsf_tx_model_inst.send({1'b1, 8'h55, 1'b0}, 1'b0);
      begin
        bits(5);
        rd_reg(AE, d);
        chk(d, ACT);
      end
    join
    bits(12);
    rd_reg(AE, d);
    chk(d, 8'h00);
    st_dat(FULL | IDL, 8'h55);
    bits(12);
    rd_reg(AS, d);
    chk(d, 8'h00);
  endtask : t_clean
  task automatic t_overrun();
    urxsf_tx_model_inst.send({1'b1, 8'h3C, 1'b0}, 1'b0);
    urxsf_tx_model_inst.send({1'b1, 8'hA5, 1'b0}, 1'b0);
    bits(12);
    st_dat(FULL | IDL | OVR, 8'h3C);
    rd_reg(AS, d);
    chk(d, 8'h00);
  endtask : t_overrun
  task automatic t_errors();
    wr_reg(AC, 8'h01 << urxsf_pkg::CTRL_PAR_EN);
    urxsf_tx_model_inst.send({1'b0, 8'h01, 1'b0}, 1'b1);
    bits(12);
    st_dat(FULL | IDL | NZ | FRM | PAR, 8'h01);
    urxsf_tx_model_inst.send({1'b1, 8'h03, 1'b0}, 1'b0);
    bits(12);
    st_dat(FULL | IDL, 8'h03);
    wr_reg(AC, 8'h00);
  endtask : t_errors
  task automatic t_break(input logic lng);
    int len;
    len = lng ? 13 : 10;
    wr_reg(AE, {5'h0, lng, 2'h0});
    rd_reg(AE, d);
    chk(d, {5'h0, lng, 2'h0});
    fork
      urxsf_tx_model_inst.hold_low(16);
      begin
        bits(len - 1);
        chk({7'h0, brk}, 8'h00);
        bits(2);
        chk({7'h0, brk}, 8'h01);
      end
    join
    bits(12);
    rd_reg(AS, d);
    chk(d & FRM, FRM);
    rd_reg(AD, d);
  endtask : t_break
  task automatic t_idle(input logic idle_count_after_stop);
    wr_reg(AC, {4'h0, idle_count_after_stop, 3'h0});
    urxsf_tx_model_inst.send({1'b1, 8'hFF, 1'b0}, 1'b0);
    bits(4);
    rd_reg(AS, d);
    chk(d & IDL, idle_count_after_stop ? 8'h00 : IDL);
    bits(10);
    st_dat(FULL | IDL, 8'hFF);
  endtask : t_idle
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_clean();
    t_overrun();
    t_errors();
    t_break(1'b0);
    t_break(1'b1);
    t_idle(1'b0);
    t_idle(1'b1);
    test_done();
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule : urxsf_top_tb
`default_nettype wire
